// file: verilog/asc_pkg.sv
// Constants for the converter sequencer: register map, fields, reset values, timing.
// Assumes a 20 MHz APB clock; all users reference names as asc_pkg::name.
package asc_pkg;
  // Printed offsets are not all multiples of four: they are indices, byte address = 4*index
  localparam logic [7:0]  IDX_CTRL_PRI  = 8'h1F;
  localparam logic [7:0]  IDX_CTRL_SEC  = 8'h9F;
  localparam logic [7:0]  IDX_RES_HI    = 8'h1E;
  localparam logic [7:0]  IDX_RES_LO    = 8'h9E;
  localparam logic [7:0]  IDX_STATUS    = 8'hA0;
  localparam logic [11:0] ADDR_CTRL_PRI = {2'h0, IDX_CTRL_PRI, 2'h0};
  localparam logic [11:0] ADDR_CTRL_SEC = {2'h0, IDX_CTRL_SEC, 2'h0};
  localparam logic [11:0] ADDR_RES_HI   = {2'h0, IDX_RES_HI, 2'h0};
  localparam logic [11:0] ADDR_RES_LO   = {2'h0, IDX_RES_LO, 2'h0};
  localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
  // Primary control fields
  localparam int          POS_CLK_LO    = 6;
  localparam int          POS_CHAN      = 3;
  localparam int          POS_GO        = 2;
  localparam int          POS_POWER     = 0;
  // Secondary control and status fields
  localparam int          POS_JUSTIFY   = 7;
  localparam int          POS_CLK_HI    = 6;
  localparam int          POS_PCFG      = 0;
  localparam int          POS_DONE_FLAG = 0;
  localparam logic [7:0]  MASK_PRI      = 8'hFD;
  localparam logic [7:0]  MASK_SEC      = 8'hCF;
  localparam logic [7:0]  RST_PRI       = 8'h00;
  localparam logic [7:0]  RST_SEC       = 8'h00;
  localparam logic [7:0]  RST_RESULT    = 8'h00;
  // Timing
  localparam int          CLK_HZ        = 20000000;
  localparam int          RC_PERIOD_NS  = 4000;
  localparam int          RC_CYCLES     = RC_PERIOD_NS / (1000000000 / CLK_HZ);
  localparam int          CONV_PERIODS  = 12;
  localparam int          RES_BITS      = 10;
  localparam logic [3:0]  CONV_LAST     = 4'(CONV_PERIODS - 1);
  typedef enum logic [2:0] {
    ASC_IDLE, ASC_RC_WAIT, ASC_SAMPLE, ASC_CONVERT, ASC_FINISH
  } asc_state_t;
endpackage

// file: verilog/asc_tad_gen.sv
// Bit-period enable generator: one-cycle pulse per bit period.
// Assumes a single clock; the internal RC source is modelled by a fixed divider.
`timescale 1ns/1ps
`default_nettype none
module asc_tad_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  output logic            tad_pulse
);
  typedef struct packed {
    logic [7:0] cnt;
  } asc_tad_t;
  asc_tad_t st_ff;
  asc_tad_t nxt_st;
  logic [7:0] last;

  always_comb begin
    case (clk_sel)
      3'h0: last = 8'h01;
      3'h1: last = 8'h07;
      3'h2: last = 8'h1F;
      3'h4: last = 8'h03;
      3'h5: last = 8'h0F;
      3'h6: last = 8'h3F;
      default: last = 8'(asc_pkg::RC_CYCLES - 1);
    endcase
    nxt_st = st_ff;
    tad_pulse = 1'b0;
    if (!run) begin
      nxt_st.cnt = 8'h00;
    end else if (st_ff.cnt >= last) begin
      nxt_st.cnt = 8'h00;
      tad_pulse = 1'b1; // [R2] [R16]
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// file: verilog/asc_sar.sv
// Successive-approximation register: tests one bit per step, MSB first.
// Assumes cmp_in is the analog comparator answer for the current trial code.
`timescale 1ns/1ps
`default_nettype none
module asc_sar (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic       cmp_in,
  output logic [9:0]      trial
);
  typedef struct packed {
    logic [9:0] code;
    logic [9:0] probe;
  } asc_sar_t;
  asc_sar_t st_ff;
  asc_sar_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      // Waiting trial is mid-scale, so the first step already decides the top bit
      nxt_st.code  = 10'h200;
      nxt_st.probe = 10'h200;
    end else if (step && st_ff.probe != 10'h000) begin
      // Keep the bit if the input is at or above the trial level [R1]
      if (!cmp_in) begin
        nxt_st.code = st_ff.code & ~st_ff.probe;
      end
      nxt_st.probe = st_ff.probe >> 1;
      // Next lower bit becomes the new trial [R16]
      nxt_st.code  = nxt_st.code | (st_ff.probe >> 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Trial code presented to the DAC, straight from the register
  assign trial = st_ff.code;
endmodule
`default_nettype wire

// file: verilog/asc_top.sv
// Converter sequencer top: APB register file, conversion sequencing, pin configuration.
// Assumes an external DAC/comparator: trial_code drives it, cmp_in answers it.
//
// Notes on behaviour
// (R1) Each conversion yields a 10-bit result
// (R2) Three-bit clock select picks bit period
// (R3) Channel field routes analog input n
// (R4) Go flag starts conversion, hardware clears
// (R5) Power bit enables the converter
// (R6) Unimplemented control bits read zero
// (R7) Justify one: right-justified, top six zero
// (R8) Justify zero: left-justified, low six zero
// (R9) Port code sets pins analog or digital
// (R10) Port code also selects the references
// (R11) Reset forces analog pins to analog
// (R12) Completion loads result, clears go, flags done
// (R13) Software waits acquisition before go
// (R14) Software follows the conversion sequence
// (R15) Software clears flag before enabling interrupts
// (R16) One result bit per bit period
// (R17) Hold element not discharged between conversions
// (R18) Reduced variants never select channels 5-7
// (R19) Conversion takes at least twelve periods
// (R20) Clearing go aborts, result kept
// (R21) After abort, acquisition restarts on channel
// (R22) RC clock waits one cycle first
// (R23) Go while powered off does nothing
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module asc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmp_in,
  output logic [9:0]       trial_code,
  output logic [2:0]       mux_sel,
  output logic             analog_on,
  output logic             sample_en,
  output logic [7:0]       pin_analog,
  output logic [1:0]       vref_pos_sel,
  output logic             vref_neg_sel,
  output logic             conv_done_flag
);
  typedef struct packed {
    logic [7:0]         ctrl_pri;
    logic [7:0]         ctrl_sec;
    logic [7:0]         res_hi;
    logic [7:0]         res_lo;
    logic               done;
    logic [3:0]         periods;
    asc_pkg::asc_state_t state;
    logic [31:0]        rdata;
    logic [7:0]         pins;
    logic [1:0]         vpos;
    logic               vneg;
  } asc_top_t;
  asc_top_t st_ff;
  asc_top_t nxt_st;

  logic       wr;
  logic       rd;
  logic       powered;
  logic       go;
  logic [2:0] clk_sel;
  logic       tad;
  logic       run_tad;
  logic       sar_clear;
  logic       sar_step;
  logic [9:0] sar_code;
  logic [3:0] pcfg;
  logic [7:0] pat;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign powered = st_ff.ctrl_pri[asc_pkg::POS_POWER];
  assign go      = st_ff.ctrl_pri[asc_pkg::POS_GO];
  assign clk_sel = {st_ff.ctrl_sec[asc_pkg::POS_CLK_HI],
                    st_ff.ctrl_pri[asc_pkg::POS_CLK_LO +: 2]}; // [R2]
  assign pcfg    = st_ff.ctrl_sec[asc_pkg::POS_PCFG +: 4];
  assign run_tad = (st_ff.state == asc_pkg::ASC_SAMPLE) ||
                   (st_ff.state == asc_pkg::ASC_CONVERT);
  assign sar_clear = (st_ff.state != asc_pkg::ASC_CONVERT);
  assign sar_step  = tad && (st_ff.state == asc_pkg::ASC_CONVERT) &&
                     (st_ff.periods < 4'(asc_pkg::RES_BITS)); // [R16]

  asc_tad_gen u_tad (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (run_tad),
    .clk_sel   (clk_sel),
    .tad_pulse (tad)
  );

  asc_sar u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (sar_clear),
    .step    (sar_step),
    .cmp_in  (cmp_in),
    .trial   (sar_code)
  );

  // Per-pin analog pattern, bit n is pin n; 1 means analog
  always_comb begin
    case (pcfg)
      4'h0, 4'h1, 4'h8: pat = 8'hFF;
      4'h2, 4'h3:       pat = 8'h1F;
      4'h4, 4'h5:       pat = 8'h0B;
      4'h9, 4'hA, 4'hB: pat = 8'h3F;
      4'hC:             pat = 8'h1F;
      4'hD:             pat = 8'h0F;
      4'hE:             pat = 8'h01;
      4'hF:             pat = 8'h0D;
      default:          pat = 8'h00;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pins = pat; // [R9]
    // vpos: 0 supply, 1 input three; vneg: 0 ground, 1 input two
    case (pcfg)
      4'h1, 4'h3, 4'h5, 4'hA: begin
        nxt_st.vpos = 2'h1; // [R10]
        nxt_st.vneg = 1'b0;
      end
      4'h8, 4'hB, 4'hC, 4'hD, 4'hF: begin
        nxt_st.vpos = 2'h1; // [R10]
        nxt_st.vneg = 1'b1;
      end
      default: begin
        nxt_st.vpos = 2'h0;
        nxt_st.vneg = 1'b0;
      end
    endcase

    // Register writes take effect at the access edge
    if (wr) begin
      case (paddr)
        asc_pkg::ADDR_CTRL_PRI: begin
          nxt_st.ctrl_pri = pwdata[7:0] & asc_pkg::MASK_PRI; // [R6]
          if (!pwdata[asc_pkg::POS_POWER]) begin
            nxt_st.ctrl_pri[asc_pkg::POS_GO] = 1'b0; // [R23]
          end
        end
        asc_pkg::ADDR_CTRL_SEC: nxt_st.ctrl_sec = pwdata[7:0] & asc_pkg::MASK_SEC; // [R6]
        asc_pkg::ADDR_RES_HI:   nxt_st.res_hi = pwdata[7:0];
        asc_pkg::ADDR_RES_LO:   nxt_st.res_lo = pwdata[7:0];
        asc_pkg::ADDR_STATUS: begin
          if (!pwdata[asc_pkg::POS_DONE_FLAG]) begin
            nxt_st.done = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Sequencer
    case (st_ff.state)
      asc_pkg::ASC_IDLE: begin
        nxt_st.periods = 4'h0;
        if (go && powered) begin
          if (clk_sel[1:0] == 2'h3) begin
            nxt_st.state = asc_pkg::ASC_RC_WAIT; // [R22]
          end else begin
            nxt_st.state = asc_pkg::ASC_SAMPLE; // [R4]
          end
        end
      end
      asc_pkg::ASC_RC_WAIT: nxt_st.state = asc_pkg::ASC_SAMPLE; // [R22]
      asc_pkg::ASC_SAMPLE: begin
        // First segment ends at the next bit-period tick
        if (tad) begin
          nxt_st.state = asc_pkg::ASC_CONVERT;
        end
      end
      asc_pkg::ASC_CONVERT: begin
        if (tad) begin
          nxt_st.periods = st_ff.periods + 4'h1;
          if (st_ff.periods == asc_pkg::CONV_LAST - 4'h1) begin
            nxt_st.state = asc_pkg::ASC_FINISH; // [R19]
          end
        end
      end
      asc_pkg::ASC_FINISH: begin
        nxt_st.state = asc_pkg::ASC_IDLE;
        if (st_ff.ctrl_sec[asc_pkg::POS_JUSTIFY]) begin
          nxt_st.res_hi = {6'h00, sar_code[9:8]}; // [R7]
          nxt_st.res_lo = sar_code[7:0];
        end else begin
          nxt_st.res_hi = sar_code[9:2]; // [R8]
          nxt_st.res_lo = {sar_code[1:0], 6'h00};
        end
        nxt_st.ctrl_pri[asc_pkg::POS_GO] = 1'b0; // [R12]
        nxt_st.done = 1'b1; // [R12]
      end
      default: nxt_st.state = asc_pkg::ASC_IDLE;
    endcase

    // Abort: go cleared or power removed, result untouched; idle resamples while powered [R20] [R21]
    if (st_ff.state != asc_pkg::ASC_IDLE && st_ff.state != asc_pkg::ASC_FINISH &&
        (!nxt_st.ctrl_pri[asc_pkg::POS_GO] || !nxt_st.ctrl_pri[asc_pkg::POS_POWER])) begin
      nxt_st.state = asc_pkg::ASC_IDLE;
    end
    // Go written while off never latches [R23]
    if (!nxt_st.ctrl_pri[asc_pkg::POS_POWER]) begin
      nxt_st.ctrl_pri[asc_pkg::POS_GO] = 1'b0;
    end

    // Read data registered in setup phase
    if (rd) begin
      case (paddr)
        asc_pkg::ADDR_CTRL_PRI: nxt_st.rdata = {24'h0, st_ff.ctrl_pri}; // [R4] [R6]
        asc_pkg::ADDR_CTRL_SEC: nxt_st.rdata = {24'h0, st_ff.ctrl_sec};
        asc_pkg::ADDR_RES_HI:   nxt_st.rdata = {24'h0, st_ff.res_hi};
        asc_pkg::ADDR_RES_LO:   nxt_st.rdata = {24'h0, st_ff.res_lo};
        asc_pkg::ADDR_STATUS:   nxt_st.rdata = {31'h0, st_ff.done};
        default:                nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.ctrl_pri <= asc_pkg::RST_PRI;
      st_ff.ctrl_sec <= asc_pkg::RST_SEC;
      st_ff.res_hi   <= asc_pkg::RST_RESULT;
      st_ff.res_lo   <= asc_pkg::RST_RESULT;
      st_ff.done     <= 1'b0;
      st_ff.periods  <= 4'h0;
      st_ff.state    <= asc_pkg::ASC_IDLE;
      st_ff.rdata    <= 32'h0000_0000;
      st_ff.pins     <= 8'hFF; // [R11]
      st_ff.vpos     <= 2'h0;
      st_ff.vneg     <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata         = st_ff.rdata;
  assign pready         = 1'b1;
  assign pslverr        = 1'b0;
  // Hold capacitor connected while powered and outside convert/finish, never discharged [R17]
  assign sample_en      = powered && (st_ff.state != asc_pkg::ASC_CONVERT) &&
                          (st_ff.state != asc_pkg::ASC_FINISH);
  assign trial_code     = sar_code;
  assign mux_sel        = st_ff.ctrl_pri[asc_pkg::POS_CHAN +: 3]; // [R3]
  assign analog_on      = powered; // [R5]
  assign pin_analog     = st_ff.pins;
  assign vref_pos_sel   = st_ff.vpos;
  assign vref_neg_sel   = st_ff.vneg;
  assign conv_done_flag = st_ff.done;
endmodule
`default_nettype wire

// file: dv/asc_top_chk.sv
// Port-level checks for the converter sequencer.
// Bound to asc_top by the bench; one pclk domain, presetn async low.
`timescale 1ns/1ps
`default_nettype none
module asc_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0]  mux_sel,
  input wire logic        analog_on,
  input wire logic        sample_en,
  input wire logic [7:0]  pin_analog,
  input wire logic [1:0]  vref_pos_sel,
  input wire logic        vref_neg_sel,
  input wire logic        conv_done_flag
);
  logic       wr_pri;
  logic       wr_sec;
  logic [11:0] since_go_ff;
  assign wr_pri = psel && penable && pwrite && paddr == asc_pkg::ADDR_CTRL_PRI;
  assign wr_sec = psel && penable && pwrite && paddr == asc_pkg::ADDR_CTRL_SEC;
  // Saturates so a long idle spell never wraps into a false short count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_go_ff <= 12'hFFF;
    else if (wr_pri && pwdata[2] && pwdata[0]) since_go_ff <= 12'h000;
    else if (since_go_ff != 12'hFFF) since_go_ff <= since_go_ff + 12'h001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pin_reset; $rose(presetn) |-> pin_analog == 8'hFF; endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pins not analog after reset");
  property p_done_power; $rose(conv_done_flag) |-> $past(analog_on); endproperty
  a_done_power: assert property (p_done_power) else $error("done while unpowered");
  property p_done_idle; $rose(conv_done_flag) |-> sample_en; endproperty
  a_done_idle: assert property (p_done_idle) else $error("done but still converting");
  property p_min_time; $rose(conv_done_flag) |-> since_go_ff >= 12'h018; endproperty
  a_min_time: assert property (p_min_time) else $error("conversion too short");
  property p_vref; vref_neg_sel |-> vref_pos_sel == 2'h1; endproperty
  a_vref: assert property (p_vref) else $error("negative ref without positive");
  // Pins follow the stored code one cycle after the register itself
  property p_cfg; wr_sec && pwdata[3:1] == 3'h3 |-> ##2 pin_analog == 8'h00; endproperty
  a_cfg: assert property (p_cfg) else $error("all-digital code left analog pins");
  property p_mux; wr_pri |=> mux_sel == $past(pwdata[5:3]); endproperty
  a_mux: assert property (p_mux) else $error("channel not routed");
  property p_power; wr_pri |=> analog_on == $past(pwdata[0]); endproperty
  a_power: assert property (p_power) else $error("power bit not followed");
endmodule
`default_nettype wire

// file: dv/asc_cmp_model.sv
// Comparator and hold element on the converter's analog side.
// Assumes the bench presents the level of the channel picked by mux_sel.
`timescale 1ns/1ps
`default_nettype none
module asc_cmp_model (
  input  wire logic       pclk,
  input  wire logic [9:0] level,
  input  wire logic       sample_en,
  input  wire logic [9:0] trial_code,
  output logic            cmp_in
);
  logic [9:0] held_ff = 10'h000;
  // Charge kept while disconnected, never discharged
  always @(posedge pclk) begin
    if (sample_en) held_ff <= level;
  end
  assign cmp_in = held_ff >= trial_code;
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the converter sequencer: APB master, comparator model.
// Assumes asc_pkg, asc_top, asc_top_chk and asc_cmp_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
  localparam logic [11:0]  PRI = asc_pkg::ADDR_CTRL_PRI;
  localparam logic [11:0]  SEC = asc_pkg::ADDR_CTRL_SEC;
  localparam logic [11:0]  ST  = asc_pkg::ADDR_STATUS;
  localparam logic [127:0] PIN = 128'hFFFF_1F1F_0B0B_0000_FF3F_3F3F_1F0F_010D;
  localparam logic [15:0]  POS = 16'hBD2A;
  localparam logic [15:0]  NEG = 16'hB900;
  localparam int           RC  = asc_pkg::RC_CYCLES;
  localparam int           DIV [8] = '{2, 8, 32, RC, 4, 16, 64, RC};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cmp_in, j;
  logic        analog_on, sample_en, vref_neg_sel, conv_done_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [9:0]  trial_code, lv [8];
  logic [2:0]  mux_sel, ch;
  logic [1:0]  vref_pos_sel;
  logic [7:0]  pin_analog;
  logic [32:0] expq [$];
  logic [32:0] e;
  logic [15:0] res;
  int          bad_count, n_tests, cyc;
  time         t0;
  asc_top u_asc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .trial_code(trial_code), .mux_sel(mux_sel),
    .analog_on(analog_on), .sample_en(sample_en), .pin_analog(pin_analog),
    .vref_pos_sel(vref_pos_sel), .vref_neg_sel(vref_neg_sel),
    .conv_done_flag(conv_done_flag));
  asc_cmp_model u_asc_cmp_model (.pclk(pclk), .level(lv[mux_sel]), .sample_en(sample_en),
    .trial_code(trial_code), .cmp_in(cmp_in));
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic c);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= w ? d : 32'h0;
    if (!w) expq.push_back({c, d});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b0, d, 1'b1);
  endtask
  task print_verdict;
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready) `CHK(pslverr, 1'b0)
    if (psel && penable && pready && !pwrite) begin
      e = expq.pop_front();
      if (e[32]) `CHK(prdata, e[31:0])
    end
  end
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(60000 * 50);
    bad_count++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    foreach (lv[i]) lv[i] = 10'h000;
    void'($urandom(82110));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(pin_analog, 8'hFF)
    rd(PRI, 32'h0);
    wr(PRI, 32'hFE);
    rd(PRI, 32'hF8);
    rd(ST, 32'h0);
    wr(SEC, 32'hFF);
    rd(SEC, 32'hCF);
    wr(12'h004, 32'hFF);
    rd(12'h004, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(SEC, 32'(c));
      @(negedge pclk);
      `CHK(pin_analog, PIN[127 - 8 * c -: 8])
      `CHK({vref_pos_sel, vref_neg_sel}, {1'b0, POS[c], NEG[c]})
      @(posedge pclk);
    end
    // Reset in mid-run must override the last port code
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(pin_analog, 8'hFF)
    for (int k = 0; k < 8; k++) begin
      ch = 3'($urandom);
      // Both justifications are certain to occur
      j = k[0];
      foreach (lv[i]) lv[i] <= 10'($urandom);
      wr(SEC, {24'h0, j, k[2], 6'h00});
      wr(ST, 32'h0);
      wr(PRI, {24'h0, k[1:0], ch, 3'h1});
      // Acquisition settles before go
      repeat (20) @(posedge pclk);
      t0 = $time;
      wr(PRI, {24'h0, k[1:0], ch, 3'h5});
      rdat = 32'h4;
      for (int n = 0; n < 2000 && rdat[2]; n++) apb(PRI, 1'b0, 32'h0, 1'b0);
      cyc = int'(($time - t0) / 50);
      `CHK(cyc >= 12 * DIV[k] && cyc <= 13 * DIV[k] + 16, 1'b1)
      res = j ? {6'h00, lv[ch]} : {lv[ch], 6'h00};
      rd(ST, 32'h1);
      rd(asc_pkg::ADDR_RES_HI, {24'h0, res[15:8]});
      rd(asc_pkg::ADDR_RES_LO, {24'h0, res[7:0]});
      rd(PRI, {24'h0, k[1:0], ch, 3'h1});
    end
    // New levels, so a conversion that ran on would show in the result
    ch = 3'($urandom % 5);
    foreach (lv[i]) lv[i] <= ~lv[i];
    wr(ST, 32'h0);
    wr(PRI, {24'h0, 2'h2, ch, 3'h1});
    repeat (20) @(posedge pclk);
    wr(PRI, {24'h0, 2'h2, ch, 3'h5});
    repeat (100) @(posedge pclk);
    // Go dropped mid-conversion with power kept
    wr(PRI, {24'h0, 2'h2, ch, 3'h1});
    repeat (900) @(posedge pclk);
    rd(ST, 32'h0);
    rd(asc_pkg::ADDR_RES_HI, {24'h0, res[15:8]});
    rd(asc_pkg::ADDR_RES_LO, {24'h0, res[7:0]});
    @(negedge pclk);
    `CHK(sample_en, 1'b1)
    print_verdict();
  end
endmodule
bind asc_top asc_top_chk u_asc_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .mux_sel(mux_sel),
  .analog_on(analog_on), .sample_en(sample_en), .pin_analog(pin_analog),
  .vref_pos_sel(vref_pos_sel), .vref_neg_sel(vref_neg_sel), .conv_done_flag(conv_done_flag));
`default_nettype wire
